// file: eeps_chk.sv
// Purpose: Link and write-cycle assertions
// Assumes: Both link ends are design modules
// Notes:   WC equals the device write-cycle length
`timescale 1ns/1ps
`default_nettype none
module eeps_chk
    import eeps_pkg::*;
#(parameter int WC = 200)(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Link and device status
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe,
    input wire logic mem_wr_out,
    input wire logic busy_out
);
    logic [5:0]  fall_cnt;
    logic [15:0] busy_cnt;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_start; $fell(sda) && scl; endsequence
    sequence s_ack_high; scl && dev_sda_oe; endsequence
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            fall_cnt <= 6'h0;
            busy_cnt <= 16'h0;
        end
        else
        begin
            fall_cnt <= $fell(scl) ? 6'h0 : fall_cnt + 6'(~&fall_cnt);
            busy_cnt <= busy_out ? busy_cnt + 16'h1 : 16'h0;
        end
    end
    a_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data moved with clock high");
    a_hold_after_fall: assert property (
        $changed(dev_sda_oe) |-> fall_cnt >= HOLD_CYCLES)
        else $error("device data moved too soon after clock fall");
    a_ack_stable: assert property (s_ack_high |=> dev_sda_oe || !scl)
        else $error("acknowledge dropped with clock high");
    a_start_quiet: assert property (s_start |=> !dev_sda_oe [*8])
        else $error("device drove data right after start");
    a_busy_no_ack: assert property (busy_out |-> !dev_sda_oe)
        else $error("device drove data while busy");
    a_wr_at_stop: assert property (
        mem_wr_out |-> scl && sda ##1 !mem_wr_out)
        else $error("array write outside a stop");
    a_wr_then_busy: assert property (mem_wr_out |=> busy_out)
        else $error("array write without busy");
    a_busy_length: assert property ($fell(busy_out) |-> busy_cnt == WC)
        else $error("busy length wrong");
endmodule : eeps_chk
`default_nettype wire

// file: eeps_device.sv
// Purpose: Serial EEPROM slave end: framing, control byte, address, write
// Assumes: Array sits outside; mem_rdata_in follows mem_addr_out same clock
// Notes:   Only the last data byte of a write is kept; there is no page buffer
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module eeps_device
    import eeps_pkg::*;
#(
    parameter int          WRITE_CYC = WRITE_CYCLES,
    parameter logic [3:0]  DEV_CODE  = DEVICE_CODE
)(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    // Serial link
    eeps_if.device           bus,
    // Straps and write protect pins
    input  wire logic        chip_sel_low_strap_in,
    input  wire logic        chip_sel_high_strap_in,
    input  wire logic        fixed_select_strap_in,
    input  wire logic        write_protect_in,
    // Array side
    input  wire logic [7:0]  mem_rdata_in,
    output logic             mem_wr_out,
    output logic [15:0]      mem_addr_out,
    output logic [7:0]       mem_wdata_out,
    output logic             busy_out
);
    localparam int WCW = $clog2(WRITE_CYC + 1);
    localparam int HW  = $clog2(HOLD_CYCLES + 1);

    if (WRITE_CYC < 1) begin : g_chk_wc
        $error("WRITE_CYC must be at least one");
    end

    typedef struct packed {
        logic            scl_m;
        logic            scl_s;
        logic            scl_p;
        logic            sda_m;
        logic            sda_s;
        logic            sda_p;
        logic [3:0]      pin_m;
        logic [3:0]      pin_s;
        eeps_dst_t       st;
        logic [7:0]      sh;
        logic [3:0]      bitcnt;
        logic [1:0]      bytecnt;
        logic            rw;
        logic            blk;
        logic [14:0]     addr;
        logic [14:0]     waddr;
        logic [7:0]      wdata;
        logic            wpend;
        logic            ack_seen;
        logic            oe;
        logic            oe_pend;
        logic [HW-1:0]   hold;
        logic            busy;
        logic [WCW-1:0]  wc_cnt;
        logic            mem_wr;
        logic [15:0]     mem_addr;
        logic [7:0]      mem_wdata;
    } eeps_dev_state_t;

    eeps_dev_state_t r;
    eeps_dev_state_t n;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic cs_lo;
    logic cs_hi;
    logic fixed_sel;
    logic wp;

    assign scl_rise   = r.scl_s & ~r.scl_p;
    assign scl_fall   = ~r.scl_s & r.scl_p;
    assign start_seen = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
    assign stop_seen  = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
    // Straps are pulled low outside when open, so low means unconnected
    assign cs_lo      = r.pin_s[0];
    assign cs_hi      = r.pin_s[1];
    assign fixed_sel  = r.pin_s[2];
    assign wp         = r.pin_s[3];

    always_comb
    begin
        n = r;
        n.scl_m    = bus.scl;
        n.scl_s    = r.scl_m;
        n.scl_p    = r.scl_s;
        n.sda_m    = bus.sda;
        n.sda_s    = r.sda_m;
        n.sda_p    = r.sda_s;
        n.pin_m    = {write_protect_in, fixed_select_strap_in,
                      chip_sel_high_strap_in, chip_sel_low_strap_in};
        n.pin_s    = r.pin_m;
        n.mem_wr   = 1'b0;
        n.mem_addr = {r.blk, r.addr};
        // Output change waits out the undefined clock fall region
        if (r.hold != '0)
        begin
            n.hold = r.hold - 1'b1;
            if (r.hold == HW'(1))
                n.oe = r.oe_pend;
        end
        if (r.busy)
        begin
            n.wc_cnt = r.wc_cnt - 1'b1;
            if (r.wc_cnt == WCW'(1))
                n.busy = 1'b0;
        end
        if (start_seen)
        begin
            n.st      = DS_RX;
            n.bitcnt  = 4'h0;
            n.bytecnt = 2'h0;
            n.oe      = 1'b0;
            n.hold    = '0;
            n.wpend   = 1'b0;
        end
        else if (stop_seen)
        begin
            n.st    = DS_IDLE;
            n.oe    = 1'b0;
            n.hold  = '0;
            n.wpend = 1'b0;
            if (r.wpend && !wp)
            begin
                n.busy      = 1'b1;
                n.wc_cnt    = WCW'(WRITE_CYC);
                n.mem_wr    = 1'b1;
                n.mem_addr  = {r.blk, r.waddr};
                n.mem_wdata = r.wdata;
            end
        end
        else
        begin
            unique case (r.st)
                DS_IDLE:
                begin
                    n.st = DS_IDLE;
                end
                DS_RX:
                begin
                    if (scl_rise && r.bitcnt != 4'h8)
                    begin
                        n.sh     = {r.sh[6:0], r.sda_s};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end
                    else if (scl_fall && r.bitcnt == 4'h8)
                    begin
                        n.st      = DS_ACK;
                        n.oe_pend = 1'b1;
                        n.hold    = HW'(HOLD_CYCLES);
                        unique case (r.bytecnt)
                            2'h0:
                            begin
                                if (r.sh[7:CTRL_CODE_LSB] == DEV_CODE &&
                                    r.sh[CTRL_CS_HI] == cs_hi &&
                                    r.sh[CTRL_CS_LO] == cs_lo &&
                                    fixed_sel &&
                                    !r.busy)
                                begin
                                    n.rw  = r.sh[CTRL_RW_BIT];
                                    n.blk = r.sh[CTRL_BLK_BIT];
                                end
                                else
                                begin
                                    n.st   = DS_IDLE;
                                    n.hold = '0;
                                end
                            end
                            2'h1:
                            begin
                                n.addr[14:8] = r.sh[6:0];
                            end
                            2'h2:
                            begin
                                n.addr[7:0] = r.sh;
                            end
                            2'h3:
                            begin
                                n.waddr = r.addr;
                                n.wdata = r.sh;
                                n.wpend = 1'b1;
                                n.addr  = r.addr + 15'h0001;
                            end
                        endcase
                    end
                end
                DS_ACK:
                begin
                    if (scl_fall)
                    begin
                        n.hold   = HW'(HOLD_CYCLES);
                        n.bitcnt = 4'h0;
                        if (r.rw == RW_READ && r.bytecnt == 2'h0)
                        begin
                            n.st      = DS_TX;
                            n.sh      = mem_rdata_in;
                            n.oe_pend = ~mem_rdata_in[7];
                        end
                        else
                        begin
                            n.st      = DS_RX;
                            n.oe_pend = 1'b0;
                            if (r.bytecnt != 2'h3)
                                n.bytecnt = r.bytecnt + 2'h1;
                        end
                    end
                end
                DS_TX:
                begin
                    if (scl_fall)
                    begin
                        n.hold = HW'(HOLD_CYCLES);
                        if (r.bitcnt == 4'h7)
                        begin
                            n.st      = DS_MACK;
                            n.oe_pend = 1'b0;
                            n.addr    = r.addr + 15'h0001;
                        end
                        else
                        begin
                            n.bitcnt  = r.bitcnt + 4'h1;
                            n.sh      = {r.sh[6:0], 1'b0};
                            n.oe_pend = ~r.sh[6];
                        end
                    end
                end
                DS_MACK:
                begin
                    if (scl_rise)
                        n.ack_seen = ~r.sda_s;
                    else if (scl_fall)
                    begin
                        n.hold = HW'(HOLD_CYCLES);
                        if (r.ack_seen)
                        begin
                            n.st      = DS_TX;
                            n.bitcnt  = 4'h0;
                            n.sh      = mem_rdata_in;
                            n.oe_pend = ~mem_rdata_in[7];
                        end
                        else
                        begin
                            n.st      = DS_IDLE;
                            n.oe_pend = 1'b0;
                        end
                    end
                end
                default:
                begin
                    n.st = DS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            r <= '0;
        else
            r <= n;
    end

    assign bus.dev_sda_oe = r.oe;
    assign mem_wr_out     = r.mem_wr;
    assign mem_addr_out   = r.mem_addr;
    assign mem_wdata_out  = r.mem_wdata;
    assign busy_out       = r.busy;
endmodule : eeps_device
`default_nettype wire

// file: eeps_if.sv
// Purpose: Two-wire link between the master end and the EEPROM end
// Assumes: Only the master drives the serial clock
// Notes:   Data line is open drain with a pull-up; enable high pulls low
`timescale 1ns/1ps
`default_nettype none
interface eeps_if;
    logic scl;
    logic mst_sda_oe;
    logic dev_sda_oe;
    logic sda;

    // Wired-AND with pull-up
    assign sda = ~(mst_sda_oe | dev_sda_oe);

    modport device (input scl, input sda, output dev_sda_oe);
    modport master (output scl, output mst_sda_oe, input sda);
endinterface : eeps_if
`default_nettype wire

// file: eeps_master.sv
// Purpose: Two-wire bus master end, ordered through AHB-Lite registers
// Assumes: Single master on the link; AHB slave with no wait states
// Notes:   A command runs start, one byte, stop in that order, each optional
`timescale 1ns/1ps
`default_nettype none
module eeps_master
    import eeps_pkg::*;
#(
    parameter int QTR = QTR_CYCLES
)(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    // Serial link
    eeps_if.master           bus,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out
);
    localparam int DW = $clog2(QTR);

    if (QTR <= HOLD_CYCLES + 4) begin : g_chk_qtr
        $error("QTR too short for the device output hold");
    end

    typedef struct packed {
        logic              sda_m;
        logic              sda_s;
        logic              scl;
        logic              oe;
        eeps_mst_t         st;
        logic [1:0]        phase;
        logic [DW-1:0]     div;
        logic              tick;
        logic [3:0]        bitcnt;
        logic [7:0]        sh;
        logic [CMD_W-1:0]  cmd;
        logic [7:0]        tx;
        logic [7:0]        rx;
        logic              nack;
        logic              busy;
        logic              a_act;
        logic              a_wr;
        eeps_ridx_t        a_idx;
        logic [31:0]       hrdata;
        logic              hready;
    } eeps_mst_state_t;

    eeps_mst_state_t r;
    eeps_mst_state_t n;

    function automatic eeps_ridx_t eeps_decode(input logic [31:0] a);
        if (a == REG_CMD_OFS)
            return RI_CMD;
        else if (a == REG_TX_OFS)
            return RI_TX;
        else if (a == REG_STAT_OFS)
            return RI_STAT;
        else
            return RI_NONE;
    endfunction : eeps_decode

    logic [31:0] stat_word;
    assign stat_word = {16'h0000, r.rx, 6'h00, r.nack, r.busy};

    always_comb
    begin
        n = r;
        n.sda_m  = bus.sda;
        n.sda_s  = r.sda_m;
        n.hready = 1'b1;
        n.a_act  = 1'b0;
        // Register bus
        if (hsel_in && hready_in && htrans_in == HTRANS_NONSEQ)
        begin
            n.a_act = 1'b1;
            n.a_wr  = hwrite_in;
            n.a_idx = eeps_decode(haddr_in);
            unique case (eeps_decode(haddr_in))
                RI_CMD:  n.hrdata = {27'h000_0000, r.cmd};
                RI_TX:   n.hrdata = {24'h00_0000, r.tx};
                RI_STAT: n.hrdata = stat_word;
                RI_NONE: n.hrdata = 32'h0000_0000;
            endcase
        end
        if (r.a_act && r.a_wr)
        begin
            if (r.a_idx == RI_CMD && !r.busy)
            begin
                n.cmd  = hwdata_in[CMD_W-1:0];
                n.busy = 1'b1;
            end
            else if (r.a_idx == RI_TX)
                n.tx = hwdata_in[7:0];
        end
        // Quarter-period tick
        n.tick = (r.div == '0);
        if (r.div == '0)
            n.div = DW'(QTR - 1);
        else
            n.div = r.div - 1'b1;
        if (r.tick)
        begin
            n.phase = r.phase + 2'h1;
            unique case (r.st)
                MS_IDLE:
                begin
                    n.phase = 2'h0;
                    if (r.busy)
                    begin
                        if (r.cmd[CMD_START_BIT])
                            n.st = MS_START;
                        else if (r.cmd[CMD_WRITE_BIT] || r.cmd[CMD_READ_BIT])
                        begin
                            n.st     = MS_BYTE;
                            n.bitcnt = 4'h0;
                            n.sh     = r.cmd[CMD_READ_BIT] ? 8'hFF : r.tx;
                        end
                        else if (r.cmd[CMD_STOP_BIT])
                            n.st = MS_STOP;
                        else
                            n.busy = 1'b0;
                    end
                end
                MS_START:
                begin
                    unique case (r.phase)
                        2'h0: n.oe = 1'b0;
                        2'h1: n.scl = 1'b1;
                        2'h2:
                        begin
                            if (r.sda_s)
                                n.oe = 1'b1;
                            else
                                n.phase = r.phase;
                        end
                        2'h3:
                        begin
                            n.scl = 1'b0;
                            n.cmd[CMD_START_BIT] = 1'b0;
                            n.st = MS_IDLE;
                        end
                    endcase
                end
                MS_BYTE:
                begin
                    unique case (r.phase)
                        2'h0:
                        begin
                            if (r.bitcnt == 4'h8)
                                n.oe = r.cmd[CMD_READ_BIT] &
                                       r.cmd[CMD_ACK_BIT];
                            else
                                n.oe = ~r.sh[7];
                        end
                        2'h1: n.scl = 1'b1;
                        2'h2:
                        begin
                            if (r.bitcnt == 4'h8)
                                n.nack = r.sda_s;
                            else
                                n.sh = {r.sh[6:0], r.sda_s};
                        end
                        2'h3:
                        begin
                            n.scl = 1'b0;
                            if (r.bitcnt == 4'h8)
                            begin
                                n.rx = r.sh;
                                n.cmd[CMD_WRITE_BIT] = 1'b0;
                                n.cmd[CMD_READ_BIT]  = 1'b0;
                                n.st = MS_IDLE;
                            end
                            else
                                n.bitcnt = r.bitcnt + 4'h1;
                        end
                    endcase
                end
                MS_STOP:
                begin
                    unique case (r.phase)
                        2'h0: n.oe = 1'b1;
                        2'h1: n.scl = 1'b1;
                        2'h2: n.oe = 1'b0;
                        2'h3:
                        begin
                            n.cmd[CMD_STOP_BIT] = 1'b0;
                            n.st = MS_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            r     <= '0;
            r.scl <= 1'b1;
            r.tx  <= TX_RESET;
        end
        else
            r <= n;
    end

    assign bus.scl        = r.scl;
    assign bus.mst_sda_oe = r.oe;
    assign hrdata_out     = r.hrdata;
    assign hreadyout_out  = r.hready;
    assign hresp_out      = 1'b0;
endmodule : eeps_master
`default_nettype wire

// file: eeps_pkg.sv
// Purpose: Shared constants and types of the serial EEPROM slave front end
// Assumes: 50 MHz system clock, 100 kHz serial clock from the master end
// Notes:   Times are kept in their own units; cycle counts derive from them
package eeps_pkg;
    // Clock and serial timing
    localparam int CLK_NS         = 20;
    localparam int CLK_KHZ        = 50_000;
    localparam int SCL_KHZ        = 100;
    localparam int QTR_CYCLES     = CLK_KHZ / (4 * SCL_KHZ);
    localparam int HOLD_NS        = 300;
    localparam int HOLD_CYCLES    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_CYCLE_MS = 5;
    localparam int WRITE_CYCLES   = WRITE_CYCLE_MS * 1_000_000 / CLK_NS;

    // Device-type code; value is arbitrary
    localparam logic [3:0] DEVICE_CODE = 4'h5;

    // Control byte layout
    localparam int CTRL_CODE_LSB = 4;
    localparam int CTRL_BLK_BIT  = 3;
    localparam int CTRL_CS_HI    = 2;
    localparam int CTRL_CS_LO    = 1;
    localparam int CTRL_RW_BIT   = 0;
    localparam logic RW_READ     = 1'h1;

    // Controller registers, byte offsets
    localparam logic [31:0] REG_CMD_OFS  = 32'h0000_0000;
    localparam logic [31:0] REG_TX_OFS   = 32'h0000_0004;
    localparam logic [31:0] REG_STAT_OFS = 32'h0000_0008;
    localparam logic [7:0]  TX_RESET     = 8'h00;

    // Command register fields
    localparam int CMD_START_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_READ_BIT  = 2;
    localparam int CMD_ACK_BIT   = 3;
    localparam int CMD_STOP_BIT  = 4;
    localparam int CMD_W         = 5;

    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    localparam int STAT_RX_LSB   = 8;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        DS_IDLE = 3'h0,
        DS_RX   = 3'h1,
        DS_ACK  = 3'h2,
        DS_TX   = 3'h3,
        DS_MACK = 3'h4
    } eeps_dst_t;

    typedef enum logic [1:0] {
        MS_IDLE  = 2'h0,
        MS_START = 2'h1,
        MS_BYTE  = 2'h2,
        MS_STOP  = 2'h3
    } eeps_mst_t;

    typedef enum logic [1:0] {
        RI_NONE = 2'h0,
        RI_CMD  = 2'h1,
        RI_TX   = 2'h2,
        RI_STAT = 2'h3
    } eeps_ridx_t;
endpackage : eeps_pkg

// file: eeps_tb_top.sv
// Purpose: Master and device ends joined on one link, driven over AHB
// Assumes: Short write cycle and quarter-bit period
// Notes:   Array model returns address high byte xor low byte
`timescale 1ns/1ps
`default_nettype none
module eeps_tb_top
    import eeps_pkg::*;
;
    localparam int WC = 3000;
    logic        mclk_in = 1'h0;
    logic        reset_n_in = 1'h0;
    logic        hsel = 1'h0;
    logic        hwrite = 1'h0;
    logic        fixed = 1'h1;
    logic        wp = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, st;
    logic        hready, mwr, busy;
    logic [15:0] maddr, wr_addr;
    logic [7:0]  wdata, wr_data;
    logic [9:0]  tbl [6] = '{10'h34C, 10'h35A, 10'h358, 10'h35E, 10'h15C,
                             10'h25C};
    int          wr_num = 0;
    int          miscompares = 0;
    int          check_count = 0;
    int          cyc = 0;
    eeps_if bus_if ();
    eeps_master #(.QTR(40)) u_eeps_master (.mclk_in(mclk_in),
        .reset_n_in(reset_n_in), .bus(bus_if.master), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out());
    eeps_device #(.WRITE_CYC(WC)) u_eeps_device (.mclk_in(mclk_in),
        .reset_n_in(reset_n_in), .bus(bus_if.device),
        .chip_sel_low_strap_in(1'h0),
        .chip_sel_high_strap_in(1'h1), .fixed_select_strap_in(fixed),
        .write_protect_in(wp), .mem_rdata_in(maddr[7:0] ^ maddr[15:8]),
        .mem_wr_out(mwr), .mem_addr_out(maddr), .mem_wdata_out(wdata),
        .busy_out(busy));
    eeps_chk #(.WC(WC)) u_eeps_chk (.mclk_in(mclk_in),
        .reset_n_in(reset_n_in), .scl(bus_if.scl), .sda(bus_if.sda),
        .dev_sda_oe(bus_if.dev_sda_oe), .mem_wr_out(mwr), .busy_out(busy));
    always #10 mclk_in = ~mclk_in;
    // Captures array writes and cuts a hang short
    always @(posedge mclk_in)
    begin
        cyc <= cyc + 1;
        if (mwr === 1'h1)
        begin
            wr_num <= wr_num + 1;
            wr_addr <= maddr;
            wr_data <= wdata;
        end
        if (cyc == 80000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [31:0] a, d);
        hsel <= 1'h1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk_in); while (hready !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        do @(posedge mclk_in); while (hready !== 1'h1);
        st = hrdata;
    endtask : ahb
    // One master command, then poll until idle and check the ninth bit
    task automatic op(input logic [4:0] cmd, input logic [7:0] tx,
                      input logic nack);
        ahb(1'h1, REG_TX_OFS, {24'h0, tx});
        ahb(1'h1, REG_CMD_OFS, {27'h0, cmd});
        do ahb(1'h0, REG_STAT_OFS, 32'h0); while (st[STAT_BUSY_BIT] !== 1'h0);
        chk(16'(st[STAT_NACK_BIT]), 16'(nack));
    endtask : op
    task automatic give_verdict();
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (10) @(posedge mclk_in);
        reset_n_in <= 1'h1;
        repeat (8) @(posedge mclk_in);
        foreach (tbl[i])
        begin
            fixed <= tbl[i][9];
            repeat (4) @(posedge mclk_in);
            op(5'h13, tbl[i][7:0], tbl[i][8]);
        end
        op(5'h03, 8'h5C, 1'h0);
        op(5'h02, 8'hC1, 1'h0);
        op(5'h02, 8'h23, 1'h0);
        op(5'h12, 8'h9D, 1'h0);
        op(5'h13, 8'h5C, 1'h1);
        chk(wr_addr, 16'hC123);
        chk({8'h0, wr_data}, 16'h009D);
        repeat (WC) @(posedge mclk_in);
        op(5'h03, 8'h5D, 1'h0);
        op(5'h14, 8'h00, 1'h1);
        chk({8'h0, st[15:8]}, 16'h00E5);
        wp <= 1'h1;
        op(5'h03, 8'h54, 1'h0);
        op(5'h02, 8'hFF, 1'h0);
        op(5'h02, 8'hFF, 1'h0);
        op(5'h12, 8'h11, 1'h0);
        op(5'h03, 8'h55, 1'h0);
        op(5'h0C, 8'h00, 1'h0);
        chk({8'h0, st[15:8]}, 16'h0000);
        op(5'h14, 8'h00, 1'h1);
        chk({8'h0, st[15:8]}, 16'h0001);
        chk(16'(wr_num), 16'h0001);
        give_verdict();
    end
endmodule : eeps_tb_top
`default_nettype wire
